// *** hw/sbc_chan_dma.sv ***
// channel buffer dma end: descriptor registers, ping/pong buffers, link clock master
// assumes apb on clk, one peer on the link, buffers held in the local memory array
// Behaviour
// - move data only in the channel's slots
// - send at once, mark block start/middle
// - short slot: keep only valid bytes
// - unconfigured transmit channel sends and reports unconfigured
// - configured channel receives every slot continuously; a receive channel with no buffer running answers busy instead
// - receiver answers only backpressure or release
// - backpressure allows a single receiver only
// - released status line allows broadcast receivers
// - depth is blocks times size plus one minus one
// - descriptor flag, depth and base layout
// - buffers up to eight kilobytes
// - async packet length in first two bytes
// - async packets at most 2048 bytes
// - software sets ready, configures before access
// - finished buffer sets done and interrupts
// - next buffer only when ready, else wait
// - single and multiple packet modes
// - single mode: one packet per buffer
// - long packet segmented, start flag marks it
// - done on packet end or buffer full
`timescale 1ns/1ns
module sbc_chan_dma #(
  parameter int N_SLOTS = 8,
  parameter int MEM_AW = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic buf_done_irq,
  sbc_link_if.dev lnk
);
  localparam int SW = $clog2(N_SLOTS);
  localparam int DW = $clog2(2 * sbc_pkg::LCLK_HALF);

  logic [31:0] mem [2**MEM_AW];
  logic ce_q, le_q, pg_q;
  logic [1:0] rdy_q, dne_q, err_q, ps_q;
  logic [12:0] depth_q [2];
  logic [31:0] base_q [2];
  logic [sbc_pkg::CFG_W-1:0] cfg_q;
  logic [N_SLOTS-1:0] slot_map_q;
  logic [MEM_AW-1:0] maddr_q;
  logic uncfg_seen_q;
  sbc_pkg::sbc_dma_st_t st_q;
  logic [13:0] ptr_q;
  logic [15:0] left_q;
  logic err_pend_q;
  logic [DW-1:0] div_q;
  logic [SW-1:0] slot_q;
  logic lclk_q, lsync_q;
  logic [37:0] s1_q, s2_q;
  sbc_pkg::sbc_cmd_t cmd_q;
  logic [2:0] cnt_q;
  logic [31:0] dat_q;
  logic oe_q, sent_q, stat_q;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire hit_d0 = paddr == sbc_pkg::OFF_DESC0;
  wire hit_bf = paddr == sbc_pkg::OFF_BUFS;
  wire hit_b1 = paddr == sbc_pkg::OFF_BASE1;
  wire hit_b2 = paddr == sbc_pkg::OFF_BASE2;
  wire hit_cf = paddr == sbc_pkg::OFF_CFG;
  wire hit_sl = paddr == sbc_pkg::OFF_SLOTS;
  wire hit_ma = paddr == sbc_pkg::OFF_MADDR;
  wire hit_md = paddr == sbc_pkg::OFF_MDATA;
  wire hit_st = paddr == sbc_pkg::OFF_STAT;
  wire mapped = |{hit_d0, hit_bf, hit_b1, hit_b2, hit_cf, hit_sl, hit_ma, hit_md, hit_st};
  wire [31:0] rd_data =
    hit_d0 ? {16'h0, ce_q, le_q, pg_q, 13'h0} :
    hit_bf ? {rdy_q[1], dne_q[1], err_q[1], depth_q[1], rdy_q[0], dne_q[0], err_q[0], depth_q[0]} :
    hit_b1 ? base_q[0] :
    hit_b2 ? base_q[1] :
    hit_cf ? {21'h0, ps_q, cfg_q} :
    hit_sl ? 32'(slot_map_q) :
    hit_ma ? 32'(maddr_q) :
    hit_md ? mem[maddr_q] :
    hit_st ? {28'h0, uncfg_seen_q, st_q} : 32'h0;

  // zero wait state: ready in every access phase, error on unmapped words
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel & ~penable) begin
        prdata <= rd_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link clock, slots and input synchroniser
  wire rise = div_q == DW'(sbc_pkg::LCLK_HALF - 1);
  wire fall = div_q == DW'(2 * sbc_pkg::LCLK_HALF - 1);
  wire [SW-1:0] slot_n = (slot_q == SW'(N_SLOTS - 1)) ? '0 : slot_q + 1'b1;
  wire sbc_pkg::sbc_cmd_t in_cmd = sbc_pkg::sbc_cmd_t'(s2_q[37:36]);
  wire [2:0] in_cnt = s2_q[35:33];
  wire [31:0] in_dat = s2_q[32:1];
  wire in_busy = s2_q[0];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_q <= '0;
      slot_q <= '0;
      lclk_q <= 1'b0;
      lsync_q <= 1'b0;
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= {lnk.cmd, lnk.cnt, lnk.dat, lnk.stat};
      s2_q <= s1_q;
      div_q <= fall ? '0 : div_q + 1'b1;
      if (rise) begin
        lclk_q <= 1'b1;
      end
      if (fall) begin
        lclk_q <= 1'b0;
        slot_q <= slot_n;
        lsync_q <= slot_n == '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // buffer walk datapath
  wire rx = cfg_q[sbc_pkg::CFG_RX];
  wire sp = cfg_q[sbc_pkg::CFG_ASYNC] & ~cfg_q[sbc_pkg::CFG_MULTI];
  wire run = st_q == sbc_pkg::ST_RUN;
  wire [13:0] bytes = {1'b0, depth_q[pg_q]} + 14'h1;
  wire [MEM_AW-1:0] wbase = base_q[pg_q][MEM_AW+1:2];
  wire [14:0] endw = 15'(wbase) + 15'((bytes + 14'h3) >> 2);
  wire bad = (base_q[pg_q][1:0] != 2'h0) | (|(base_q[pg_q] >> (MEM_AW + 2))) | (endw > 15'(2**MEM_AW));
  wire [15:0] tx_len = mem[wbase][15:0];
  // only slots mapped to this logical channel move data
  wire mine_c = slot_map_q[slot_q];
  wire mine_n = slot_map_q[slot_n];
  wire data_cmd = (in_cmd == sbc_pkg::CMD_BLOCK_START) | (in_cmd == sbc_pkg::CMD_MID_BLOCK);
  // a slot refused with backpressure comes again later, so storing it now would duplicate it
  wire rx_ok = fall & rx & mine_c & run & ~stat_q & data_cmd & (in_cnt != 3'h0) & (in_cnt <= 3'h4);
  wire rx_pkt = rx_ok & sp & (in_cmd == sbc_pkg::CMD_BLOCK_START);
  wire rx_long = rx_pkt & (in_dat[15:0] > sbc_pkg::PKT_MAX);
  wire adv = rx_ok | (fall & ~rx & sent_q & ~in_busy);
  wire [2:0] step = rx ? in_cnt : cnt_q;
  wire [13:0] ptr_a = ptr_q + (adv ? 14'(step) : 14'h0);
  wire [15:0] left_a = rx_pkt ? in_dat[15:0] - 16'(step) : (adv ? left_q - 16'(step) : left_q);
  // one packet per buffer in single mode: stop at packet end or full buffer
  wire fin = adv & ((ptr_a >= bytes) | (sp & (left_a == 16'h0)));
  wire [13:0] rem = bytes - ptr_a;
  wire [15:0] lim = (sp && left_a < 16'(rem)) ? left_a : 16'(rem);
  wire [2:0] tcnt = (lim > 16'(sbc_pkg::SLOT_BYTES)) ? 3'(sbc_pkg::SLOT_BYTES) : lim[2:0];
  wire [31:0] tword = mem[wbase + MEM_AW'(ptr_a[13:2])];
  wire send = ~rx & ce_q & mine_n & run & ~fin;
  wire first = (ptr_a == 14'h0) & (~cfg_q[sbc_pkg::CFG_ASYNC] | ps_q[pg_q]);
  wire go = (st_q == sbc_pkg::ST_IDLE) & ce_q & rdy_q[pg_q] & ~dne_q[pg_q];
  wire done_ev = st_q == sbc_pkg::ST_DONE;
  wire [MEM_AW-1:0] rx_wa [4];
  wire [1:0] rx_lane [4];
  for (genvar g = 0; g < 4; g++) begin : g_rxb
    wire [13:0] b = ptr_q + 14'(g);
    assign rx_wa[g] = wbase + MEM_AW'(b[13:2]);
    assign rx_lane[g] = b[1:0];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= sbc_pkg::ST_IDLE;
      ptr_q <= 14'h0;
      left_q <= 16'h0;
      err_pend_q <= 1'b0;
    end else begin
      unique case (st_q)
        sbc_pkg::ST_IDLE: begin
          if (go) begin
            ptr_q <= 14'h0;
            err_pend_q <= bad;
            st_q <= bad ? sbc_pkg::ST_DONE : sbc_pkg::ST_RUN;
            if (~rx & sp & ps_q[pg_q]) begin
              left_q <= tx_len;
            end
          end
        end
        sbc_pkg::ST_RUN: begin
          ptr_q <= ptr_a;
          left_q <= left_a;
          if (rx_long) begin
            err_pend_q <= 1'b1;
            st_q <= sbc_pkg::ST_DONE;
          end else if (fin) begin
            st_q <= sbc_pkg::ST_DONE;
          end else if (~ce_q) begin
            st_q <= sbc_pkg::ST_IDLE;
          end
        end
        sbc_pkg::ST_DONE: begin
          st_q <= sbc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // descriptor and configuration registers; hardware sets come last so they win
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ce_q <= 1'b0;
      le_q <= 1'b0;
      pg_q <= 1'b0;
      rdy_q <= 2'h0;
      dne_q <= 2'h0;
      err_q <= 2'h0;
      ps_q <= 2'h0;
      depth_q[0] <= 13'h0;
      depth_q[1] <= 13'h0;
      base_q[0] <= 32'h0;
      base_q[1] <= 32'h0;
      cfg_q <= '0;
      slot_map_q <= '0;
      maddr_q <= '0;
      uncfg_seen_q <= 1'b0;
      buf_done_irq <= 1'b0;
    end else begin
      if (wr & hit_d0) begin
        ce_q <= pwdata[sbc_pkg::CE_POS];
        le_q <= pwdata[sbc_pkg::LE_POS];
        pg_q <= pwdata[sbc_pkg::PG_POS];
      end
      if (wr & hit_bf) begin
        rdy_q <= {pwdata[sbc_pkg::BUF2_LSB+sbc_pkg::RDY_POS], pwdata[sbc_pkg::RDY_POS]};
        dne_q <= {pwdata[sbc_pkg::BUF2_LSB+sbc_pkg::DNE_POS], pwdata[sbc_pkg::DNE_POS]};
        err_q <= {pwdata[sbc_pkg::BUF2_LSB+sbc_pkg::ERR_POS], pwdata[sbc_pkg::ERR_POS]};
        depth_q[0] <= pwdata[sbc_pkg::DEPTH_W-1:0];
        depth_q[1] <= pwdata[sbc_pkg::BUF2_LSB+sbc_pkg::DEPTH_W-1:sbc_pkg::BUF2_LSB];
      end
      if (wr & hit_b1) begin
        base_q[0] <= pwdata;
      end
      if (wr & hit_b2) begin
        base_q[1] <= pwdata;
      end
      if (wr & hit_cf) begin
        cfg_q <= pwdata[sbc_pkg::CFG_W-1:0];
        ps_q <= pwdata[sbc_pkg::CFG_PS_LSB+1:sbc_pkg::CFG_PS_LSB];
      end
      if (wr & hit_sl) begin
        slot_map_q <= pwdata[N_SLOTS-1:0];
      end
      if (wr & hit_ma) begin
        maddr_q <= pwdata[MEM_AW-1:0];
      end else if (acc & hit_md) begin
        maddr_q <= maddr_q + 1'b1;
      end
      if (wr & hit_st) begin
        uncfg_seen_q <= 1'b0;
      end
      // unconfigured marker is reported, never stored
      if (fall & rx & mine_c & (in_cmd == sbc_pkg::CMD_CHANNEL_UNCONFIGURED)) begin
        uncfg_seen_q <= 1'b1;
      end
      if (rx_pkt) begin
        ps_q[pg_q] <= 1'b1;
      end
      buf_done_irq <= done_ev;
      if (done_ev) begin
        dne_q[pg_q] <= 1'b1;
        err_q[pg_q] <= err_q[pg_q] | err_pend_q;
        pg_q <= ~pg_q;
        if (le_q) begin
          ce_q <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // buffer memory: apb window and received bytes
  always_ff @(posedge clk) begin
    if (wr & hit_md) begin
      mem[maddr_q] <= pwdata;
    end
    for (int i = 0; i < 4; i++) begin
      if (rx_ok && 3'(i) < in_cnt) begin
        mem[rx_wa[i]][{rx_lane[i], 3'b000} +: 8] <= in_dat[8*i +: 8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link outputs change only when the link clock falls
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_q <= sbc_pkg::CMD_NONE;
      cnt_q <= 3'h0;
      dat_q <= 32'h0;
      oe_q <= 1'b0;
      sent_q <= 1'b0;
      stat_q <= 1'b0;
    end else if (fall) begin
      // an owned slot of a configured channel with nothing to send is left undriven
      oe_q <= ~rx & mine_n & (send | ~ce_q);
      sent_q <= send;
      cnt_q <= send ? tcnt : 3'h0;
      dat_q <= send ? tword : 32'h0;
      if (~ce_q) begin
        cmd_q <= sbc_pkg::CMD_CHANNEL_UNCONFIGURED;
      end else if (send) begin
        cmd_q <= first ? sbc_pkg::CMD_BLOCK_START : sbc_pkg::CMD_MID_BLOCK;
      end else begin
        cmd_q <= sbc_pkg::CMD_NONE;
      end
      // busy only while no buffer is running; otherwise the line is released
      stat_q <= rx & ce_q & mine_n & ~run;
    end
  end

  assign lnk.lclk = lclk_q;
  assign lnk.lsync = lsync_q;
  assign lnk.dev_cmd = cmd_q;
  assign lnk.dev_cnt = cnt_q;
  assign lnk.dev_dat = dat_q;
  assign lnk.dev_oe = oe_q;
  assign lnk.dev_stat = stat_q;
  assign lnk.dev_stat_oe = stat_q;
endmodule // sbc_chan_dma

// *** hw/sbc_pkg.sv ***
// constants and types shared by the channel dma end, the bus peer and the link interface
// assumes a 20 MHz system clock on both ends
package sbc_pkg;
  localparam int CLK_NS = 50;
  localparam int LCLK_NS = 400;
  // half period of the link clock in system clocks
  localparam int LCLK_HALF = LCLK_NS / (2 * CLK_NS);
  localparam logic [7:0] OFF_DESC0 = 8'h00;
  localparam logic [7:0] OFF_BUFS = 8'h04;
  localparam logic [7:0] OFF_BASE1 = 8'h08;
  localparam logic [7:0] OFF_BASE2 = 8'h0C;
  localparam logic [7:0] OFF_CFG = 8'h10;
  localparam logic [7:0] OFF_SLOTS = 8'h14;
  localparam logic [7:0] OFF_MADDR = 8'h18;
  localparam logic [7:0] OFF_MDATA = 8'h1C;
  localparam logic [7:0] OFF_STAT = 8'h20;
  localparam int CE_POS = 15;
  localparam int LE_POS = 14;
  localparam int PG_POS = 13;
  localparam int RDY_POS = 15;
  localparam int DNE_POS = 14;
  localparam int ERR_POS = 13;
  localparam int DEPTH_W = 13;
  localparam int BUF2_LSB = 16;
  localparam int CFG_RX = 0;
  localparam int CFG_ASYNC = 1;
  localparam int CFG_MULTI = 2;
  localparam int CFG_ID_LSB = 3;
  localparam int ID_W = 6;
  localparam int CFG_W = 9;
  localparam int CFG_PS_LSB = 9;
  localparam int SLOT_BYTES = 4;
  localparam logic [15:0] PKT_MAX = 16'h0800;
  typedef enum logic [1:0] {
    CMD_NONE = 2'h0,
    CMD_CHANNEL_UNCONFIGURED = 2'h1,
    CMD_BLOCK_START = 2'h2,
    CMD_MID_BLOCK = 2'h3
  } sbc_cmd_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RUN = 3'h2,
    ST_DONE = 3'h4
  } sbc_dma_st_t;
endpackage

// *** hw/sbc_link_if.sv ***
// serial media link between the channel dma end and one bus peer
// assumes the testbench instantiates it once and hands each end its modport
`timescale 1ns/1ns
interface sbc_link_if;
  logic lclk;
  logic lsync;
  sbc_pkg::sbc_cmd_t dev_cmd;
  logic [2:0] dev_cnt;
  logic [31:0] dev_dat;
  logic dev_oe;
  logic dev_stat;
  logic dev_stat_oe;
  sbc_pkg::sbc_cmd_t peer_cmd;
  logic [2:0] peer_cnt;
  logic [31:0] peer_dat;
  logic peer_oe;
  logic peer_stat;
  logic peer_stat_oe;
  sbc_pkg::sbc_cmd_t cmd;
  logic [2:0] cnt;
  logic [31:0] dat;
  logic stat;
  // shared lines: only the slot owner drives; status idles low (accepting)
  assign cmd = dev_oe ? dev_cmd : (peer_oe ? peer_cmd : sbc_pkg::CMD_NONE);
  assign cnt = dev_oe ? dev_cnt : (peer_oe ? peer_cnt : 3'h0);
  assign dat = dev_oe ? dev_dat : (peer_oe ? peer_dat : 32'h0);
  assign stat = (dev_stat_oe & dev_stat) | (peer_stat_oe & peer_stat);
  modport dev (
    output lclk, lsync, dev_cmd, dev_cnt, dev_dat, dev_oe, dev_stat, dev_stat_oe,
    input cmd, cnt, dat, stat
  );
  modport peer (
    input lclk, lsync, cmd, cnt, dat, stat,
    output peer_cmd, peer_cnt, peer_dat, peer_oe, peer_stat, peer_stat_oe
  );
endinterface

// *** hw/sbc_peer.sv ***
// bus peer end: sends or receives words in its slots of the serial media link
// assumes the link clock and frame sync come from the dma end on another clock
`timescale 1ns/1ns
module sbc_peer #(
  parameter int N_SLOTS = 8
) (
  input wire logic clk,
  input wire logic nrst,
  sbc_link_if.peer lnk,
  input wire logic tx_mode,
  input wire logic [N_SLOTS-1:0] slot_map,
  input wire logic tx_valid,
  input wire logic [1:0] tx_cmd,
  input wire logic [2:0] tx_cnt,
  input wire logic [31:0] tx_data,
  output logic tx_taken,
  output logic rx_valid,
  output logic [1:0] rx_cmd,
  output logic [2:0] rx_cnt,
  output logic [31:0] rx_data,
  input wire logic rx_busy
);
  localparam int SW = $clog2(N_SLOTS);
  logic [39:0] s1_q, s2_q;
  logic prev_q;
  logic [SW-1:0] slot_q;
  sbc_pkg::sbc_cmd_t cmd_q;
  logic [2:0] cnt_q;
  logic [31:0] dat_q;
  logic oe_q, sent_q, seen_q, stat_q;

  ////////////////////////////////////////////////////////////////////////////
  // synchronised link view and edge detect
  wire l2 = s2_q[39];
  wire in_sync = s2_q[38];
  wire sbc_pkg::sbc_cmd_t in_cmd = sbc_pkg::sbc_cmd_t'(s2_q[37:36]);
  wire [2:0] in_cnt = s2_q[35:33];
  wire [31:0] in_dat = s2_q[32:1];
  wire in_busy = s2_q[0];
  wire rise = l2 & ~prev_q;
  wire fall = ~l2 & prev_q;
  wire [SW-1:0] slot_n = (slot_q == SW'(N_SLOTS - 1)) ? '0 : slot_q + 1'b1;
  wire [SW-1:0] slot_r = in_sync ? '0 : slot_n;
  wire mine_r = slot_map[slot_r];
  wire mine_n = slot_map[slot_n];
  // unused lanes of a short slot read as zero
  wire [31:0] lane_msk = {{8{in_cnt > 3'h3}}, {8{in_cnt > 3'h2}}, {8{in_cnt > 3'h1}}, {8{in_cnt > 3'h0}}};
  wire take_rx = rise & ~tx_mode & mine_r & ~stat_q & (in_cmd != sbc_pkg::CMD_NONE);
  wire hold = sent_q & seen_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= '0;
      s2_q <= '0;
      prev_q <= 1'b0;
      slot_q <= '0;
      rx_valid <= 1'b0;
      rx_cmd <= 2'h0;
      rx_cnt <= 3'h0;
      rx_data <= 32'h0;
      seen_q <= 1'b0;
    end else begin
      s1_q <= {lnk.lclk, lnk.lsync, lnk.cmd, lnk.cnt, lnk.dat, lnk.stat};
      s2_q <= s1_q;
      prev_q <= l2;
      rx_valid <= take_rx;
      if (rise) begin
        slot_q <= slot_r;
      end
      if (rise & oe_q) begin
        seen_q <= in_busy;
      end
      if (take_rx) begin
        rx_cmd <= in_cmd;
        rx_cnt <= in_cnt;
        rx_data <= in_dat & lane_msk;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // drive side: a refused word is repeated in the next owned slot
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_q <= sbc_pkg::CMD_NONE;
      cnt_q <= 3'h0;
      dat_q <= 32'h0;
      oe_q <= 1'b0;
      sent_q <= 1'b0;
      stat_q <= 1'b0;
      tx_taken <= 1'b0;
    end else begin
      tx_taken <= 1'b0;
      if (fall) begin
        // drive only a word on offer or one being repeated
        oe_q <= tx_mode & mine_n & (hold | tx_valid);
        stat_q <= ~tx_mode & mine_n & rx_busy;
        if (tx_mode & mine_n & ~hold) begin
          sent_q <= tx_valid;
          tx_taken <= tx_valid;
          cmd_q <= tx_valid ? sbc_pkg::sbc_cmd_t'(tx_cmd) : sbc_pkg::CMD_NONE;
          cnt_q <= tx_valid ? tx_cnt : 3'h0;
          dat_q <= tx_valid ? tx_data : 32'h0;
        end
      end
    end
  end

  assign lnk.peer_cmd = cmd_q;
  assign lnk.peer_cnt = cnt_q;
  assign lnk.peer_dat = dat_q;
  assign lnk.peer_oe = oe_q;
  assign lnk.peer_stat = stat_q;
  assign lnk.peer_stat_oe = stat_q;
endmodule // sbc_peer

// *** sim/sbc_link_properties.sv ***
// link checker: slot timing and line ownership on the serial media link
// assumes instantiation beside the link interface, clocked by the dma end's clock
`timescale 1ns/1ns
module sbc_link_properties (
  input wire logic clk,
  input wire logic nrst,
  input wire logic lclk,
  input wire logic lsync,
  input wire sbc_pkg::sbc_cmd_t cmd,
  input wire logic [2:0] cnt,
  input wire logic [31:0] dat,
  input wire logic dev_oe,
  input wire logic peer_oe,
  input wire logic dev_stat_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  chk_single_owner: assert property (!(dev_oe && peer_oe))
    else $error("both ends drive the link");
  chk_lclk_period: assert property ($rose(lclk) |-> lclk[*4] ##1 !lclk[*4] ##1 lclk)
    else $error("link clock not four high four low");
  chk_sync_slot: assert property ($rose(lsync) |-> $fell(lclk) ##0 lsync[*8] ##1 !lsync)
    else $error("frame sync not one whole slot");
  // device drive and status ownership may only move at a slot boundary
  chk_slot_aligned: assert property ($changed({dev_oe, dev_stat_oe}) |-> $fell(lclk))
    else $error("device drive changed inside a slot");
  chk_word_stable: assert property (dev_oe && !$fell(lclk) |-> $stable(cmd) && $stable(cnt) && $stable(dat))
    else $error("device word changed inside a slot");
  chk_cnt_range: assert property ((dev_oe || peer_oe) && cmd != sbc_pkg::CMD_CHANNEL_UNCONFIGURED
    |-> cnt >= 3'h1 && cnt <= 3'h4)
    else $error("byte count outside one to four");
  chk_cmd_driven: assert property (dev_oe |-> cmd != sbc_pkg::CMD_NONE)
    else $error("device slot without command");
  chk_stat_rx_only: assert property (dev_stat_oe |-> !dev_oe)
    else $error("status driven while transmitting");
endmodule // sbc_link_properties

// *** sim/test_serial_bus_channel_buffer_dma.sv ***
// testbench: apb register tasks on the dma end, peer tasks on the far end
// assumes one link joins both ends; registers and memory window as in sbc_pkg
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin miscompares++; \
  $display("wrong value %s exp %h got %h", nm, ex, got); end end
module test_serial_bus_channel_buffer_dma;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, irq, tx_mode, tx_valid, tx_taken, rx_valid, rx_busy;
  logic [7:0] paddr, slot_map;
  logic [31:0] pwdata, prdata, tx_data, rx_data, r;
  logic [1:0] tx_cmd, rx_cmd;
  logic [2:0] tx_cnt, rx_cnt;
  logic e;
  int miscompares = 0, checks = 0, irqs = 0;
  sbc_link_if lnk ();
  sbc_chan_dma i_sbc_chan_dma (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .buf_done_irq(irq), .lnk(lnk.dev));
  sbc_peer i_sbc_peer (.clk(clk), .nrst(nrst), .lnk(lnk.peer), .tx_mode(tx_mode), .slot_map(slot_map),
    .tx_valid(tx_valid), .tx_cmd(tx_cmd), .tx_cnt(tx_cnt), .tx_data(tx_data), .tx_taken(tx_taken),
    .rx_valid(rx_valid), .rx_cmd(rx_cmd), .rx_cnt(rx_cnt), .rx_data(rx_data), .rx_busy(rx_busy));
  sbc_link_properties i_sbc_link_properties (.clk(clk), .nrst(nrst), .lclk(lnk.lclk), .lsync(lnk.lsync),
    .cmd(lnk.cmd), .cnt(lnk.cnt), .dat(lnk.dat), .dev_oe(lnk.dev_oe), .peer_oe(lnk.peer_oe),
    .dev_stat_oe(lnk.dev_stat_oe));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (irq === 1'b1) irqs++;
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #(20000 * 50);
    miscompares++;
    end_of_test();
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, ex, r)
  endtask
  // polls rather than waits a fixed time: slot position is not known here
  task automatic wait_bit(input logic [7:0] a, input int b);
    for (int i = 0; i < 300; i++) begin
      apb(1'b0, a, 32'h0);
      if (r[b] === 1'b1) break;
    end
  endtask
  task automatic get_rx(input bit skip_unconf);
    do @(posedge clk);
    while (rx_valid !== 1'b1 || (skip_unconf && rx_cmd === sbc_pkg::CMD_CHANNEL_UNCONFIGURED));
  endtask
  task automatic send(input logic [1:0] c, input logic [31:0] d);
    @(posedge clk);
    tx_valid <= 1'b1; tx_cmd <= c; tx_cnt <= 3'h4; tx_data <= d;
    do @(posedge clk); while (tx_taken !== 1'b1);
    tx_valid <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    tx_mode = 1'b0; slot_map = 8'h02; tx_valid = 1'b0; tx_cmd = 2'h0; tx_cnt = 3'h4; tx_data = 32'h0;
    rx_busy = 1'b0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rd(sbc_pkg::OFF_STAT, 32'h1, "state");
    rd(sbc_pkg::OFF_DESC0, 32'h0, "desc0");
    apb(1'b0, 8'h40, 32'h0);
    `CHK("slverr", 1'b1, e)
    wr(sbc_pkg::OFF_BUFS, 32'h1FFF_1FFF);
    rd(sbc_pkg::OFF_BUFS, 32'h1FFF_1FFF, "depths");
    // transmit: one buffer of seven bytes, second buffer not ready
    wr(sbc_pkg::OFF_MADDR, 32'h0);
    wr(sbc_pkg::OFF_MDATA, 32'h4433_2211);
    wr(sbc_pkg::OFF_MDATA, 32'hAABB_CCDD);
    wr(sbc_pkg::OFF_BASE1, 32'h0);
    wr(sbc_pkg::OFF_BASE2, 32'h2);
    wr(sbc_pkg::OFF_CFG, 32'h0);
    wr(sbc_pkg::OFF_SLOTS, 32'h2);
    get_rx(1'b0);
    `CHK("unconf", sbc_pkg::CMD_CHANNEL_UNCONFIGURED, rx_cmd)
    wr(sbc_pkg::OFF_BUFS, 32'h0000_8006);
    wr(sbc_pkg::OFF_DESC0, 32'h8000);
    get_rx(1'b1);
    `CHK("cmd0", sbc_pkg::CMD_BLOCK_START, rx_cmd)
    `CHK("word0", 32'h4433_2211, rx_data)
    get_rx(1'b1);
    `CHK("cmd1", sbc_pkg::CMD_MID_BLOCK, rx_cmd)
    `CHK("cnt1", 3'h3, rx_cnt)
    `CHK("word1", 32'h00BB_CCDD, rx_data)
    wait_bit(sbc_pkg::OFF_BUFS, 14);
    rd(sbc_pkg::OFF_BUFS, 32'h0000_C006, "done1");
    rd(sbc_pkg::OFF_DESC0, 32'hA000, "pg");
    repeat (100) @(posedge clk);
    rd(sbc_pkg::OFF_STAT, 32'h1, "wait");
    `CHK("irq1", 1, irqs)
    // misaligned second buffer must finish with error
    wr(sbc_pkg::OFF_BUFS, 32'h8003_C006);
    wait_bit(sbc_pkg::OFF_BUFS, 30);
    rd(sbc_pkg::OFF_BUFS, 32'hE003_C006, "err2");
    `CHK("irq2", 2, irqs)
    // receive: peer sends two words into the first buffer, last entry stops it
    wr(sbc_pkg::OFF_DESC0, 32'h0);
    wr(sbc_pkg::OFF_CFG, 32'h1);
    wr(sbc_pkg::OFF_BASE1, 32'h20);
    wr(sbc_pkg::OFF_BUFS, 32'h0000_8007);
    repeat (70) @(posedge clk);
    tx_mode <= 1'b1;
    wr(sbc_pkg::OFF_DESC0, 32'hC000);
    send(sbc_pkg::CMD_BLOCK_START, 32'h1234_5678);
    send(sbc_pkg::CMD_MID_BLOCK, 32'h9ABC_DEF0);
    wait_bit(sbc_pkg::OFF_BUFS, 14);
    rd(sbc_pkg::OFF_DESC0, 32'h6000, "le");
    wr(sbc_pkg::OFF_MADDR, 32'h8);
    rd(sbc_pkg::OFF_MDATA, 32'h1234_5678, "rx0");
    rd(sbc_pkg::OFF_MDATA, 32'h9ABC_DEF0, "rx1");
    `CHK("irq3", 3, irqs)
    // unconfigured marker from the peer is reported in status, nothing stored
    wr(sbc_pkg::OFF_STAT, 32'h0);
    rd(sbc_pkg::OFF_STAT, 32'h1, "cleared");
    send(sbc_pkg::CMD_CHANNEL_UNCONFIGURED, 32'h0);
    repeat (20) @(posedge clk);
    rd(sbc_pkg::OFF_STAT, 32'h9, "uncfg");
    end_of_test();
  end
endmodule // test_serial_bus_channel_buffer_dma
